// file: design/btp_defines.vh
`ifndef BTP_DEFINES_VH
`define BTP_DEFINES_VH
// command codes of the three configuration registers
`define BTP_ADDR_UV_SEL 8'hBA
`define BTP_ADDR_HV_OV_SEL 8'hBB
`define BTP_ADDR_PH_REM 8'hBC
// reset values
`define BTP_RST_UV_SEL 8'h00
`define BTP_RST_HV_OV_SEL 8'h00
`define BTP_RST_PH_REM 8'h00
// decoded thresholds while every select code is zero
`define BTP_RST_LV_UV_PMIL 10'h352
`define BTP_RST_HV_UV_PCT 10'h04B
`define BTP_RST_HV_OV_WARN_PCT 10'h06C
`define BTP_RST_HV_OV_PROT_PCT 10'h07D
// writable bit masks, reserved bits read zero
`define BTP_MASK_UV_SEL 8'h3F
`define BTP_MASK_HV_OV_SEL 8'h3F
`define BTP_MASK_PH_REM 8'hBF
// field positions
`define BTP_LO_FIELD_LSB 0
`define BTP_HI_FIELD_LSB 3
`define BTP_RAIL_DIS_BIT 7
`define BTP_NUM_PHASES 6
`endif

// file: design/btp_phase_gate.v
`timescale 1ns/10ps
`default_nettype none
// holds one phase pwm low while that phase is removed
module btp_phase_gate (
   input wire clk_sys,
   input wire rst_n,
   input wire clk_en,
   input wire removed,
   input wire pwm_raw,
   output reg pwm_out
);
   // registered gate, inactive whenever removed
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out <= 1'b0;
      end else if (clk_en) begin
         pwm_out <= pwm_raw & ~removed; // R10
      end
   end
endmodule // btp_phase_gate
`default_nettype wire

// file: design/btp_regs.v
// Function
// R01: low bus undervoltage warning code, bits 2:0
// R02: high bus undervoltage warning code, bits 5:3
// R03: high bus overvoltage warning code, bits 2:0
// R04: high bus overvoltage protection code, bits 5:3
// R05: bits 0-3 set remove phases one-four
// R06: bits 4-5 set remove phases five-six
// R07: bit 7 set disables supply rail detection
// R08: phase register rw, protectable, resets 00h
// R09: overvoltage register rw, protectable, bits 7:6 reserved
// R10: removed phase pwm held inactive
`timescale 1ns/10ps
`default_nettype none
`include "btp_defines.vh"
module btp_regs (
   input wire clk_sys,
   input wire nrst,
   input wire clk_en,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] reg_addr,
   input wire [7:0] wr_data,
   input wire write_protect,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output wire addr_hit,
   input wire [5:0] pwm_raw,
   output wire [5:0] pwm_out,
   output wire [5:0] phase_active,
   output wire rail_detect_en,
   output reg [9:0] lv_uv_warn_pmil,
   output reg [9:0] hv_uv_warn_pct,
   output reg [9:0] hv_ov_warn_pct,
   output reg [9:0] hv_ov_prot_pct
);
   reg [1:0] rst_sync;
   wire rst_n;
   reg [7:0] uv_sel;
   reg [7:0] hv_ov_sel;
   reg [7:0] ph_rem;
   wire wr_ok;

   // register decode, used for writes and reads
   function [1:0] dec;
      input [7:0] a;
      begin
         case (a)
            `BTP_ADDR_UV_SEL: dec = 2'h1;
            `BTP_ADDR_HV_OV_SEL: dec = 2'h2;
            `BTP_ADDR_PH_REM: dec = 2'h3;
            default: dec = 2'h0;
         endcase
      end
   endfunction

   // reset release through two flops
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign addr_hit = (dec(reg_addr) != 2'h0);
   assign wr_ok = wr_en & ~write_protect; // R08 R09

   // register writes, reserved bits forced to zero
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         uv_sel <= `BTP_RST_UV_SEL; // R01 R02
         hv_ov_sel <= `BTP_RST_HV_OV_SEL; // R09
         ph_rem <= `BTP_RST_PH_REM; // R08
      end else if (clk_en && wr_ok) begin
         case (dec(reg_addr))
            2'h1: uv_sel <= wr_data & `BTP_MASK_UV_SEL;
            2'h2: hv_ov_sel <= wr_data & `BTP_MASK_HV_OV_SEL; // R09
            2'h3: ph_rem <= wr_data & `BTP_MASK_PH_REM; // R08
            default: uv_sel <= uv_sel;
         endcase
      end
   end

   // read data registered; unmapped reads return zero
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else if (clk_en) begin
         rd_valid <= rd_en;
         if (rd_en) begin
            case (dec(reg_addr))
               2'h1: rd_data <= uv_sel;
               2'h2: rd_data <= hv_ov_sel;
               2'h3: rd_data <= ph_rem;
               default: rd_data <= 8'h00;
            endcase
         end
      end
   end

   // low bus undervoltage warning code to tenths of a percent
   function [9:0] lv_uv_pmil;
      input [2:0] code;
      begin
         case (code)
            3'h0: lv_uv_pmil = 10'h352; // 85.0 percent, the reset setting
            3'h1: lv_uv_pmil = 10'h339;
            3'h2: lv_uv_pmil = 10'h320;
            3'h3: lv_uv_pmil = 10'h307;
            3'h4: lv_uv_pmil = 10'h2EE;
            3'h5: lv_uv_pmil = 10'h2D5;
            3'h6: lv_uv_pmil = 10'h36B; // codes 6 and 7 sit above the reset setting
            default: lv_uv_pmil = 10'h384;
         endcase
      end
   endfunction

   // high bus undervoltage warning code to percent
   function [9:0] hv_uv_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: hv_uv_pct = 10'h04B;
            3'h1: hv_uv_pct = 10'h047;
            3'h2: hv_uv_pct = 10'h043;
            3'h3: hv_uv_pct = 10'h03F;
            3'h4: hv_uv_pct = 10'h03A;
            3'h5: hv_uv_pct = 10'h036;
            3'h6: hv_uv_pct = 10'h04F;
            default: hv_uv_pct = 10'h053;
         endcase
      end
   endfunction

   // high bus overvoltage warning code to percent
   function [9:0] ov_warn_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: ov_warn_pct = 10'h06C;
            3'h1: ov_warn_pct = 10'h06E;
            3'h2: ov_warn_pct = 10'h071;
            3'h3: ov_warn_pct = 10'h075;
            3'h4: ov_warn_pct = 10'h079;
            3'h5: ov_warn_pct = 10'h07D;
            3'h6: ov_warn_pct = 10'h06A; // codes 6 and 7 sit below the reset setting
            default: ov_warn_pct = 10'h068;
         endcase
      end
   endfunction

   // high bus overvoltage protection code to percent
   function [9:0] ov_prot_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: ov_prot_pct = 10'h07D;
            3'h1: ov_prot_pct = 10'h081;
            3'h2: ov_prot_pct = 10'h085;
            3'h3: ov_prot_pct = 10'h08A;
            3'h4: ov_prot_pct = 10'h08E;
            3'h5: ov_prot_pct = 10'h092;
            3'h6: ov_prot_pct = 10'h096;
            default: ov_prot_pct = 10'h079; // top code wraps below the reset setting
         endcase
      end
   endfunction

   // low bus undervoltage warning, one edge after its register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lv_uv_warn_pmil <= `BTP_RST_LV_UV_PMIL;
      end else if (clk_en) begin
         lv_uv_warn_pmil <= lv_uv_pmil(uv_sel[`BTP_LO_FIELD_LSB +: 3]); // R01
      end
   end

   // high bus undervoltage warning, one edge after its register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hv_uv_warn_pct <= `BTP_RST_HV_UV_PCT;
      end else if (clk_en) begin
         hv_uv_warn_pct <= hv_uv_pct(uv_sel[`BTP_HI_FIELD_LSB +: 3]); // R02
      end
   end

   // high bus overvoltage warning, one edge after its register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hv_ov_warn_pct <= `BTP_RST_HV_OV_WARN_PCT;
      end else if (clk_en) begin
         hv_ov_warn_pct <= ov_warn_pct(hv_ov_sel[`BTP_LO_FIELD_LSB +: 3]); // R03
      end
   end

   // high bus overvoltage protection, one edge after its register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hv_ov_prot_pct <= `BTP_RST_HV_OV_PROT_PCT;
      end else if (clk_en) begin
         hv_ov_prot_pct <= ov_prot_pct(hv_ov_sel[`BTP_HI_FIELD_LSB +: 3]); // R04
      end
   end

   // supply rail supervision enabled while bit 7 is clear
   assign rail_detect_en = ~ph_rem[`BTP_RAIL_DIS_BIT]; // R07
   assign phase_active = ~ph_rem[5:0]; // R05 R06

   // one pwm gate per phase
   genvar g;
   generate
      for (g = 0; g < `BTP_NUM_PHASES; g = g + 1) begin : gen_ph
         btp_phase_gate u_gate (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .removed(ph_rem[g]), // R05 R06
            .pwm_raw(pwm_raw[g]),
            .pwm_out(pwm_out[g])
         );
      end
   endgenerate
endmodule // btp_regs
`default_nettype wire

// file: test/btp_props.sv
`timescale 1ns/10ps
`default_nettype none
module btp_props (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic rd_en,
   input wire logic rd_valid,
   input wire logic [5:0] pwm_raw,
   input wire logic [5:0] pwm_out,
   input wire logic [5:0] phase_active,
   input wire logic [9:0] lv_uv_warn_pmil,
   input wire logic [9:0] hv_uv_warn_pct,
   input wire logic [9:0] hv_ov_warn_pct,
   input wire logic [9:0] hv_ov_prot_pct
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // read answer pulses exactly once
   rd_pulse_a: assert property (clk_en && rd_en |=> rd_valid) else $error("no pulse");
   rd_idle_a: assert property (clk_en && !rd_en |=> !rd_valid) else $error("stray");
   // removed phase pwm held low one cycle late
   pwm_gate_a: assert property (
      $past(clk_en) |-> pwm_out == ($past(pwm_raw) & $past(phase_active))) else $error("pwm");
   // decoded thresholds stay within their tables
   lv_code_a: assert property (
      lv_uv_warn_pmil inside {850,825,800,775,750,725,875,900}) else $error("lv");
   hv_uv_a: assert property (
      hv_uv_warn_pct inside {75,71,67,63,58,54,79,83}) else $error("hv uv");
   ov_warn_a: assert property (
      hv_ov_warn_pct inside {108,110,113,117,121,125,106,104}) else $error("ov warn");
   ov_prot_a: assert property (
      hv_ov_prot_pct inside {125,129,133,138,142,146,150,121}) else $error("ov prot");
   frozen_cfg_a: assert property (
      !clk_en |=> $stable(hv_ov_prot_pct) && $stable(lv_uv_warn_pmil)) else $error("frozen");
   cover property (rd_valid);
   cover property (!clk_en);
   cover property (pwm_raw != 0 && phase_active != 6'h3F);
endmodule // btp_props
`default_nettype wire

// file: test/btp_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module btp_regs_tb;
   logic clk_sys, nrst, clk_en, wr_en, rd_en, write_protect, rd_valid, addr_hit, rail_detect_en;
   logic [7:0] reg_addr, wr_data, rd_data;
   logic [5:0] pwm_raw, pwm_out, phase_active;
   logic [9:0] lv_uv_warn_pmil, hv_uv_warn_pct, hv_ov_warn_pct, hv_ov_prot_pct;
   int num_errors = 0;
   int total_checks = 0;
   logic [9:0] lvt [8] = '{850, 825, 800, 775, 750, 725, 875, 900};
   logic [9:0] hut [8] = '{75, 71, 67, 63, 58, 54, 79, 83};
   logic [9:0] owt [8] = '{108, 110, 113, 117, 121, 125, 106, 104};
   logic [9:0] opt [8] = '{125, 129, 133, 138, 142, 146, 150, 121};
   btp_regs btp_regs_i (.*);
   task chk(input logic [9:0] s, input logic [9:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1;
      {reg_addr, wr_data, wr_en} = {a, d, 1'b1};
      @(posedge clk_sys) #1;
      wr_en = 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys) #1;
      {reg_addr, rd_en} = {a, 1'b1};
      @(posedge clk_sys) #1;
      rd_en = 0;
      chk(rd_valid, 1);
      chk(rd_data, e);
   endtask
   task t_reset;
      rd(8'hBA, 8'h00);
      rd(8'hBB, 8'h00);
      rd(8'hBC, 8'h00);
      chk(addr_hit, 1);
      chk(lv_uv_warn_pmil, 850);
      chk(hv_uv_warn_pct, 75);
      chk(hv_ov_warn_pct, 108);
      chk(hv_ov_prot_pct, 125);
      chk(phase_active, 6'h3F);
      chk(rail_detect_en, 1);
   endtask
   // every code of both fields, the two fields opposed
   task t_codes;
      for (int i = 0; i < 8; i++) begin
         logic [2:0] j;
         j = 3'(7 - i);
         wr(8'hBA, {2'b11, j, i[2:0]});
         wr(8'hBB, {2'b11, j, i[2:0]});
         @(posedge clk_sys) #1;
         chk(lv_uv_warn_pmil, lvt[i]);
         chk(hv_uv_warn_pct, hut[j]);
         chk(hv_ov_warn_pct, owt[i]);
         chk(hv_ov_prot_pct, opt[j]);
         rd(8'hBB, {2'b00, j, i[2:0]});
      end
   endtask
   task t_phase;
      pwm_raw = 6'h3F;
      wr(8'hBC, 8'hFF);
      rd(8'hBC, 8'hBF);
      chk(phase_active, 0);
      chk(rail_detect_en, 0);
      chk(pwm_out, 0);
      wr(8'hBC, 8'h15);
      repeat (2) @(posedge clk_sys) #1;
      chk(pwm_out, 6'h2A);
      chk(rail_detect_en, 1);
   endtask
   // protected and frozen writes are dropped, unmapped read is zero
   task t_prot;
      write_protect = 1;
      wr(8'hBC, 0);
      write_protect = 0;
      rd(8'hBC, 8'h15);
      clk_en = 0;
      wr(8'hBB, 8'h3F);
      clk_en = 1;
      rd(8'hBB, 8'h07);
      rd(8'h00, 0);
      chk(addr_hit, 0);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #5000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      {nrst, wr_en, rd_en, write_protect, reg_addr, wr_data, pwm_raw} = 0;
      clk_en = 1;
      repeat (2) @(posedge clk_sys);
      #1 nrst = 1;
      repeat (2) @(posedge clk_sys);
      t_reset;
      t_codes;
      t_phase;
      t_prot;
      tally_and_finish;
   end
endmodule // btp_regs_tb
bind btp_regs btp_props btp_props_i (.*);
`default_nettype wire
